//--- verilog/burst_port_pkg.sv
/*
  Shared constants and types of the burst SRAM port model: word and address
  widths, burst phase figures counted in input-clock edges, width modes and
  the burst slot record. Assumes nothing of its surroundings.
*/
package burst_port_pkg;

  localparam int WORD_W = 18;
  localparam int ADDR_W = 8;
  localparam int MASK_W = 2;
  localparam int PH_W = 4;
  localparam int WR_SLOTS = 2;
  localparam int RD_SLOTS = 3;

  // edges counted from the starting positive-clock rise (edge 0)
  localparam logic [PH_W-1:0] PH_BUSY = 4'h1;
  localparam logic [PH_W-1:0] WR_PH_FIRST = 4'h2;
  localparam logic [PH_W-1:0] WR_PH_LAST = 4'h5;
  localparam logic [PH_W-1:0] RD_PH_FIRST = 4'h5;
  localparam logic [PH_W-1:0] RD_PH_LAST = 4'h8;

  localparam logic [WORD_W-1:0] WORD_ZERO = 18'h00000;
  localparam int X18_LOW_TOP = 8;
  localparam int X8_LOW_TOP = 3;
  localparam int X8_HIGH_TOP = 7;
  localparam int X9_TOP = 8;

  typedef enum logic [1:0] {
    MODE_X8 = 2'b00,
    MODE_X9 = 2'b01,
    MODE_X18 = 2'b10
  } width_mode_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [PH_W-1:0] ph;
  } burst_slot_t;

  localparam burst_slot_t SLOT_IDLE = '{valid: 1'b0, addr: 8'h00, ph: 4'h0};

endpackage : burst_port_pkg

//--- verilog/lane_enable.sv
/*
  Expands the active-low write masks of one beat into per-bit write enables
  for the configured width. Purely combinational; assumes the masks are
  already sampled on the beat's clock edge.
*/
`timescale 1ns/1ns
`default_nettype none

module lane_enable
  import burst_port_pkg::*;
(
  input wire width_mode_t width_mode,
  input wire logic [MASK_W-1:0] byte_lane_write_mask_n,
  input wire logic [MASK_W-1:0] nibble_lane_write_mask_n,
  output logic [WORD_W-1:0] bit_en
);

  genvar b;
  generate
    for (b = 0; b < WORD_W; b++) begin : g_bit
      always_comb begin
        case (width_mode)
          MODE_X18: bit_en[b] = (b <= X18_LOW_TOP) ? ~byte_lane_write_mask_n[0]
                                                   : ~byte_lane_write_mask_n[1];
          MODE_X8: bit_en[b] = (b <= X8_LOW_TOP) ? ~nibble_lane_write_mask_n[0]
                             : (b <= X8_HIGH_TOP) ? ~nibble_lane_write_mask_n[1]
                             : 1'b0;
          MODE_X9: bit_en[b] = (b <= X9_TOP) ? ~byte_lane_write_mask_n[0] : 1'b0;
          default: bit_en[b] = 1'b0;
        endcase
      end
    end
  endgenerate

endmodule // lane_enable

`default_nettype wire

//--- verilog/burst_sram_port.sv
/*
  Burst-of-four SRAM with separate read and write data ports and a shared
  address bus. Each input-clock rise (positive or negative) arrives as a
  one-cycle strobe synchronous to clk; clk cycles with no strobe are a
  stopped input clock. Assumes the host never raises both strobes at once.
*/
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Write data is taken and read data launched on rises of both input clocks.
// - The start address is the first burst word and the next three consecutive locations are the others.
// - A read or a write started on the positive rise right after one of the same kind is ignored.
// - A select that started a transfer on the previous positive rise is a don't-care on this one.
// - After reset both ports are idle and the read outputs are not driven.
// - While the input clocks stand still every data pin keeps its state.
// - In 18-bit width two byte masks enable bits 8 to 0 and 17 to 9 on each beat.
// - In 8-bit width two nibble masks enable bits 3 to 0 and 7 to 4 on each beat.
// - In 9-bit width one mask enables bits 8 to 0 or nothing on each beat.
// - A beat with every mask high leaves the memory untouched.
// - Each beat's mask is applied on its own, so masks may change from beat to beat.
module burst_sram_port
  import burst_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic k_rise,
  input wire logic kn_rise,
  input wire width_mode_t width_mode,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [WORD_W-1:0] write_data,
  input wire logic [MASK_W-1:0] byte_lane_write_mask_n,
  input wire logic [MASK_W-1:0] nibble_lane_write_mask_n,
  output logic [WORD_W-1:0] read_data,
  output logic read_data_oe
);

  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

  burst_slot_t wr_slot_reg [WR_SLOTS];
  burst_slot_t wr_slot_next [WR_SLOTS];
  burst_slot_t rd_slot_reg [RD_SLOTS];
  burst_slot_t rd_slot_next [RD_SLOTS];
  logic [WORD_W-1:0] q_reg, q_next;
  logic q_oe_reg, q_oe_next;

  logic edge_any;
  logic wr_recent, rd_recent, wr_start, rd_start, wr_placed, rd_placed;
  logic wr_beat, rd_beat;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [WORD_W-1:0] bit_en;
  logic mem_we;
  logic [PH_W-1:0] ph_now;
  // helper state for the assertions
  logic prev_wr_start_reg, prev_wr_start_next;
  logic prev_rd_start_reg, prev_rd_start_next;

  assign edge_any = k_rise | kn_rise;

  lane_enable u_lane_enable (
    .width_mode(width_mode),
    .byte_lane_write_mask_n(byte_lane_write_mask_n),
    .nibble_lane_write_mask_n(nibble_lane_write_mask_n),
    .bit_en(bit_en)
  );

  // burst slot bookkeeping for both ports
  always_comb begin
    wr_recent = 1'b0;
    rd_recent = 1'b0;
    wr_beat = 1'b0;
    rd_beat = 1'b0;
    wr_addr = '0;
    rd_addr = '0;
    wr_placed = 1'b0;
    rd_placed = 1'b0;
    ph_now = '0;
    for (int i = 0; i < WR_SLOTS; i++) begin
      if (wr_slot_reg[i].valid && wr_slot_reg[i].ph == PH_BUSY) wr_recent = 1'b1;
    end
    for (int i = 0; i < RD_SLOTS; i++) begin
      if (rd_slot_reg[i].valid && rd_slot_reg[i].ph == PH_BUSY) rd_recent = 1'b1;
    end
    wr_start = k_rise && !write_port_select_n && !wr_recent;
    rd_start = k_rise && !read_port_select_n && !rd_recent;
    for (int i = 0; i < WR_SLOTS; i++) begin
      wr_slot_next[i] = wr_slot_reg[i];
      if (edge_any && wr_slot_reg[i].valid) begin
        ph_now = wr_slot_reg[i].ph + 4'h1;
        wr_slot_next[i].ph = ph_now;
        if (ph_now >= WR_PH_FIRST && ph_now <= WR_PH_LAST) begin
          wr_beat = 1'b1;
          wr_addr = wr_slot_reg[i].addr + ADDR_W'(ph_now - WR_PH_FIRST);
        end
        if (ph_now == WR_PH_LAST) wr_slot_next[i].valid = 1'b0;
      end else if (wr_start && !wr_slot_reg[i].valid && !wr_placed) begin
        wr_placed = 1'b1;
        wr_slot_next[i] = '{valid: 1'b1, addr: address, ph: '0};
      end
    end
    for (int i = 0; i < RD_SLOTS; i++) begin
      rd_slot_next[i] = rd_slot_reg[i];
      if (edge_any && rd_slot_reg[i].valid) begin
        ph_now = rd_slot_reg[i].ph + 4'h1;
        rd_slot_next[i].ph = ph_now;
        if (ph_now >= RD_PH_FIRST && ph_now <= RD_PH_LAST) begin
          rd_beat = 1'b1;
          rd_addr = rd_slot_reg[i].addr + ADDR_W'(ph_now - RD_PH_FIRST);
        end
        if (ph_now == RD_PH_LAST) rd_slot_next[i].valid = 1'b0;
      end else if (rd_start && !rd_slot_reg[i].valid && !rd_placed) begin
        rd_placed = 1'b1;
        rd_slot_next[i] = '{valid: 1'b1, addr: address, ph: '0};
      end
    end
    if (rst) begin
      for (int i = 0; i < WR_SLOTS; i++) wr_slot_next[i] = SLOT_IDLE;
      for (int i = 0; i < RD_SLOTS; i++) rd_slot_next[i] = SLOT_IDLE;
    end
  end

  // write data is only looked at on a beat of a pending burst
  assign mem_we = !rst && wr_beat && (|bit_en);

  // read output launch
  always_comb begin
    q_next = q_reg;
    q_oe_next = q_oe_reg;
    if (rst) begin
      q_next = WORD_ZERO;
      q_oe_next = 1'b0;
    end else if (edge_any) begin
      q_oe_next = rd_beat;
      if (rd_beat) q_next = mem[rd_addr];
    end
  end

  always_ff @(posedge clk) begin
    wr_slot_reg <= wr_slot_next;
    rd_slot_reg <= rd_slot_next;
    q_reg <= q_next;
    q_oe_reg <= q_oe_next;
  end

  // masked lanes keep their stored bits
  always_ff @(posedge clk) begin
    if (mem_we) mem[wr_addr] <= (mem[wr_addr] & ~bit_en) | (write_data & bit_en);
  end

  assign read_data = q_reg;
  assign read_data_oe = q_oe_reg;

  // starts taken on the last positive rise, tracked apart from the slot phases
  // so that the back-to-back checks do not lean on the logic they guard
  always_comb begin
    prev_wr_start_next = prev_wr_start_reg;
    prev_rd_start_next = prev_rd_start_reg;
    if (rst) begin
      prev_wr_start_next = 1'b0;
      prev_rd_start_next = 1'b0;
    end else if (k_rise) begin
      prev_wr_start_next = wr_start;
      prev_rd_start_next = rd_start;
    end
  end

  always_ff @(posedge clk) begin
    prev_wr_start_reg <= prev_wr_start_next;
    prev_rd_start_reg <= prev_rd_start_next;
  end

  // the output may only come on at a strobe that carries a read beat
  AST_OE_NEEDS_BEAT: assert property (@(posedge clk) disable iff (rst)
    $past(edge_any) && read_data_oe |-> $past(rd_beat)) else $error("read driven without beat");
  AST_RD_BACK_TO_BACK: assert property (@(posedge clk) disable iff (rst)
    k_rise && prev_rd_start_reg |-> !rd_start) else $error("second read accepted");
  AST_WR_DONT_CARE: assert property (@(posedge clk) disable iff (rst)
    k_rise && prev_wr_start_reg |-> !wr_start)
    else $error("write select honoured on following rise");
  AST_WR_ONLY_ON_BEAT: assert property (@(posedge clk) disable iff (rst)
    mem_we |-> edge_any && wr_beat) else $error("memory written outside a beat");
  AST_RESET_QUIET: assert property (@(posedge clk)
    rst |=> !read_data_oe && !wr_beat && !rd_beat) else $error("not idle after reset");
  AST_HOLD_STOPPED: assert property (@(posedge clk) disable iff (rst)
    !edge_any && !$past(rst) |=> $stable(read_data) && $stable(read_data_oe))
    else $error("pins moved while clocks stopped");
  AST_X18_LOW: assert property (@(posedge clk) disable iff (rst)
    width_mode == MODE_X18 && byte_lane_write_mask_n == 2'h2 |-> bit_en == 18'h001FF)
    else $error("x18 low lane wrong");
  AST_X8_HIGH: assert property (@(posedge clk) disable iff (rst)
    width_mode == MODE_X8 && nibble_lane_write_mask_n == 2'h1 |-> bit_en == 18'h000F0)
    else $error("x8 high nibble wrong");
  AST_X18_HIGH: assert property (@(posedge clk) disable iff (rst)
    width_mode == MODE_X18 && byte_lane_write_mask_n == 2'h1 |-> bit_en == 18'h3FE00)
    else $error("x18 high lane wrong");
  AST_X8_LOW: assert property (@(posedge clk) disable iff (rst)
    width_mode == MODE_X8 && nibble_lane_write_mask_n == 2'h2 |-> bit_en == 18'h0000F)
    else $error("x8 low nibble wrong");
  AST_X9_OFF: assert property (@(posedge clk) disable iff (rst)
    width_mode == MODE_X9 && byte_lane_write_mask_n[0] |-> bit_en == 18'h00000)
    else $error("x9 masked beat writes");
  AST_ALL_MASKED: assert property (@(posedge clk) disable iff (rst)
    wr_beat && bit_en == 18'h00000 |-> !mem_we) else $error("masked beat wrote memory");
  AST_NOP_IDLE: assert property (@(posedge clk) disable iff (rst)
    k_rise && read_port_select_n && write_port_select_n && !rd_beat |=> !read_data_oe)
    else $error("output driven during idle");
  AST_RD_WORD: assert property (@(posedge clk) disable iff (rst)
    edge_any && rd_beat |=> read_data == $past(mem[rd_addr])) else $error("wrong read word");

  // main scenarios: write, read, refused start, stopped clocks
  COV_WRITE: cover property (@(posedge clk) disable iff (rst) wr_start ##[1:12] mem_we);
  COV_READ: cover property (@(posedge clk) disable iff (rst) rd_start ##[1:20] read_data_oe);
  COV_IGNORED: cover property (@(posedge clk) disable iff (rst)
    k_rise && !read_port_select_n && rd_recent);
  COV_STOPPED: cover property (@(posedge clk) disable iff (rst) read_data_oe ##1 (!edge_any)[*4]);
  COV_DUP_WRITE: cover property (@(posedge clk) disable iff (rst)
    k_rise && !write_port_select_n && prev_wr_start_reg);

endmodule // burst_sram_port

`default_nettype wire

//--- test/host_model.sv
/*
  Host controller model: drives input-clock strobes, selects, address,
  write data and masks. Assumes the caller invokes its tasks at a falling clk edge.
*/
`timescale 1ns/1ns
`default_nettype none

module host_model
  import burst_port_pkg::*;
(
  input wire logic clk,
  output logic k_rise,
  output logic kn_rise,
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic [ADDR_W-1:0] address,
  output logic [WORD_W-1:0] write_data,
  output logic [MASK_W-1:0] byte_lane_write_mask_n,
  output logic [MASK_W-1:0] nibble_lane_write_mask_n
);
  initial begin
    k_rise = 1'b0;
    kn_rise = 1'b0;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    address = 8'h00;
    write_data = 18'h00000;
    byte_lane_write_mask_n = 2'h3;
    nibble_lane_write_mask_n = 2'h3;
  end

  // one input-clock rise; address and write data lines not in use show the inverse of their last value
  task automatic drive(input logic is_k, input logic rs_n, input logic ws_n, input logic beat,
                       input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                       input logic [MASK_W-1:0] bm, input logic [MASK_W-1:0] nm);
    k_rise = is_k;
    kn_rise = ~is_k;
    read_port_select_n = rs_n;
    write_port_select_n = ws_n;
    address = (is_k && !(rs_n && ws_n)) ? a : ~address;
    write_data = beat ? d : ~write_data;
    byte_lane_write_mask_n = bm;
    nibble_lane_write_mask_n = nm;
  endtask

  // both input clocks stand still
  task automatic idle();
    k_rise = 1'b0;
    kn_rise = 1'b0;
  endtask
endmodule // host_model

`default_nettype wire

//--- test/test_quad_rate_sram_port_protocol.sv
/*
  Self-checking bench of the burst SRAM port with a host model and a
  reference memory. Assumes the design and host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module test_quad_rate_sram_port_protocol;
  import burst_port_pkg::*;
  logic clk, rst, k_rise, kn_rise, rps_n, wps_n, read_data_oe, w, r;
  width_mode_t width_mode;
  logic [ADDR_W-1:0] address;
  logic [WORD_W-1:0] write_data, read_data;
  logic [MASK_W-1:0] bm_n, nm_n;
  logic [WORD_W-1:0] ref_mem [256];
  int fail_count, total_checks;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  host_model host(.clk(clk), .k_rise(k_rise), .kn_rise(kn_rise), .read_port_select_n(rps_n),
    .write_port_select_n(wps_n), .address(address), .write_data(write_data),
    .byte_lane_write_mask_n(bm_n), .nibble_lane_write_mask_n(nm_n));

  burst_sram_port DUT(.clk(clk), .rst(rst), .k_rise(k_rise), .kn_rise(kn_rise),
    .width_mode(width_mode), .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .address(address), .write_data(write_data), .byte_lane_write_mask_n(bm_n),
    .nibble_lane_write_mask_n(nm_n), .read_data(read_data), .read_data_oe(read_data_oe));

  function automatic logic [WORD_W-1:0] lanes(width_mode_t md, logic [1:0] bm, logic [1:0] nm);
    case (md)
      MODE_X18: return {{9{~bm[1]}}, {9{~bm[0]}}};
      MODE_X9: return {9'h000, {9{~bm[0]}}};
      MODE_X8: return {10'h000, {4{~nm[1]}}, {4{~nm[0]}}};
      default: return WORD_ZERO;
    endcase
  endfunction

  task automatic check(input string name, input logic [WORD_W-1:0] exp,
                       input logic [WORD_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rd(input logic rd, input logic [ADDR_W-1:0] a, input int i);
    if (rd && i >= 6 && i <= 9) begin
      check("read_data", ref_mem[a + ADDR_W'(i - 6)], read_data);
      check("read_data_oe", 18'h00001, {17'h00000, read_data_oe});
    end
    if (i == 0 || i == 10) check("read_data_oe", WORD_ZERO, {17'h00000, read_data_oe});
  endtask

  // one burst; dup repeats the start on the next positive rise
  task automatic run(input logic wr, input logic rd, input logic dup, input logic full,
                     input logic [ADDR_W-1:0] a);
    logic [WORD_W-1:0] d, be;
    logic [MASK_W-1:0] bm, nm;
    logic [ADDR_W-1:0] p;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      chk_rd(rd, a, i);
      if ($urandom_range(3) == 0) begin
        host.idle();
        @(negedge clk);
        chk_rd(rd, a, i);
      end
      d = WORD_W'($urandom);
      bm = full ? 2'h0 : MASK_W'($urandom);
      nm = full ? 2'h0 : MASK_W'($urandom);
      p = a + ADDR_W'(i - 2);
      if (wr && i >= 2 && i <= 5) begin
        be = lanes(width_mode, bm, nm);
        ref_mem[p] = (ref_mem[p] & ~be) | (d & be);
      end
      host.drive(1'(i % 2 == 0), ~((i == 0 || (i == 2 && dup)) && rd),
        ~((i == 0 || (i == 2 && dup)) && wr), wr && i >= 2 && i <= 5,
        i == 0 ? a : a ^ 8'h5A, d, bm, nm);
    end
    @(negedge clk);
    chk_rd(rd, a, 10);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    width_mode = MODE_X18;
    void'($urandom(32'h4BB9));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check("read_data_oe", WORD_ZERO, {17'h00000, read_data_oe});
    for (int a = 0; a < 256; a += 4) run(1'b1, 1'b0, 1'b0, 1'b1, ADDR_W'(a));
    run(1'b1, 1'b1, 1'b0, 1'b0, 8'hFE);
    run(1'b1, 1'b1, 1'b1, 1'b0, 8'h10);
    run(1'b0, 1'b1, 1'b0, 1'b0, 8'h4A);
    for (int n = 0; n < 60; n++) begin
      width_mode = width_mode_t'(2'($urandom_range(3)));
      w = 1'($urandom_range(1));
      r = ~w | 1'($urandom_range(1));
      run(w, r, 1'b0, 1'b0, ADDR_W'($urandom));
    end
    wrap_up();
  end
endmodule // test_quad_rate_sram_port_protocol

`default_nettype wire
